//--- logic/pmt_pkg.sv
// Constants and types shared by the program memory and table read block.
package pmt_pkg;

    // ----------------------------------------------------------------
    // Program store geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int PROG_DEPTH = 4096;
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam logic [11:0] LAST_PAGE_BASE = 12'hF00;
    localparam int PTR_HI_W = 4;

    // ----------------------------------------------------------------
    // Serial programming frame: command bit, 12 address bits, 16 data bits
    // ----------------------------------------------------------------
    localparam logic [4:0] FRAME_ADDR_END = 5'h0D;
    localparam logic [4:0] FRAME_LEN = 5'h1D;
    localparam logic CMD_READ = 1'b0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef enum logic [0:0] {
        TBL_IDLE,
        TBL_READ
    } pmt_table_state_type;

endpackage : pmt_pkg

//--- logic/pmt_program_memory.sv
// Flash program store with instruction fetch, table read and serial programming port.
`timescale 1ns/1ps

module pmt_program_memory (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Core fetch control
    input wire logic pc_load_i,
    input wire logic [11:0] pc_load_addr_i,
    output logic [11:0] pc_o,
    output logic [15:0] instr_o,
    output logic instr_valid_o,
    output logic core_stall_o,
    // Core special register writes
    input wire logic [7:0] reg_wdata_i,
    input wire logic tblp_wr_i,
    input wire logic tbhp_wr_i,
    input wire logic table_high_latch_wr_i,
    output logic [7:0] tblp_o,
    output logic [7:0] tbhp_o,
    output logic [7:0] table_high_latch_o,
    // Table read requests
    input wire logic table_read_op_i,
    input wire logic table_read_lastpage_op_i,
    input wire logic [7:0] table_dest_addr_i,
    output logic dm_wr_o,
    output logic [7:0] dm_addr_o,
    output logic [7:0] dm_wdata_o,
    // Serial programming and debug pins
    input wire logic prog_mode_i,
    input wire logic on_chip_debug_i,
    input wire logic prog_serial_clock_i,
    input wire logic prog_serial_data_i,
    output logic prog_serial_data_o,
    output logic prog_serial_data_oe_o,
    output logic shared_func_en_o
);

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [15:0] prog_mem [0:pmt_pkg::PROG_DEPTH-1];
    logic [11:0] pc_r;
    logic [15:0] instr_r;
    logic instr_valid_r;
    logic [7:0] tblp_r;
    logic [7:0] tbhp_r;
    logic [7:0] table_high_latch_r;
    logic [11:0] tbl_addr_r;
    logic [11:0] tbl_addr_nxt;
    logic [7:0] tbl_dest_r;
    pmt_pkg::pmt_table_state_type tbl_state_r;
    logic dm_wr_r;
    logic [7:0] dm_addr_r;
    logic [7:0] dm_wdata_r;
    logic [2:0] sck_sync_r;
    logic [1:0] sda_sync_r;
    logic [1:0] mode_sync_r;
    logic [1:0] dbg_sync_r;
    logic sck_rise;
    logic sck_fall;
    logic prog_active;
    logic [4:0] bit_cnt_r;
    logic [28:0] shift_in_r;
    logic [15:0] shift_out_r;
    logic sda_out_r;
    logic sda_oe_r;
    logic frame_read_r;
    logic mem_wr;
    logic [11:0] mem_wr_addr;
    logic [15:0] mem_wr_data;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // The serial clock is slow against clk_i, so it is sampled and its
    // edges found here rather than used as a second clock domain.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sck_sync_r <= 3'h0;
            sda_sync_r <= 2'h0;
            mode_sync_r <= 2'h0;
            dbg_sync_r <= 2'h0;
        end
        else
        begin
            sck_sync_r <= {sck_sync_r[1:0], prog_serial_clock_i};
            sda_sync_r <= {sda_sync_r[0], prog_serial_data_i};
            mode_sync_r <= {mode_sync_r[0], prog_mode_i};
            dbg_sync_r <= {dbg_sync_r[0], on_chip_debug_i};
        end
    end

    assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
    assign sck_fall = ~sck_sync_r[1] & sck_sync_r[2];
    assign prog_active = mode_sync_r[1];

    // ----------------------------------------------------------------
    // Program counter and instruction fetch
    // ----------------------------------------------------------------
    // The fetch stalls during the extra table cycle and while the
    // programmer owns the store, so it never sees a half-written word.
    assign core_stall_o = (tbl_state_r == pmt_pkg::TBL_READ) | prog_active;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_r <= pmt_pkg::RESET_VECTOR;
            instr_r <= pmt_pkg::WORD_RESET;
            instr_valid_r <= 1'b0;
        end
        else if (core_stall_o)
        begin
            instr_valid_r <= 1'b0;
        end
        else
        begin
            instr_r <= prog_mem[pc_r];
            instr_valid_r <= 1'b1;
            if (pc_load_i)
            begin
                pc_r <= pc_load_addr_i;
            end
            else
            begin
                pc_r <= pc_r + 12'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Table pointers and table high latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tblp_r <= pmt_pkg::PTR_RESET;
            tbhp_r <= pmt_pkg::PTR_RESET;
        end
        else
        begin
            if (tblp_wr_i)
            begin
                tblp_r <= reg_wdata_i;
            end
            if (tbhp_wr_i)
            begin
                tbhp_r <= reg_wdata_i;
            end
        end
    end

    // Software writes to the latch are dropped; an interrupt routine that
    // reads tables will therefore overwrite what the main routine left.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            table_high_latch_r <= pmt_pkg::LATCH_RESET;
        end
        else if (tbl_state_r == pmt_pkg::TBL_READ)
        begin
            table_high_latch_r <= prog_mem[tbl_addr_r][15:8];
        end
    end

    // ----------------------------------------------------------------
    // Table read sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        if (table_read_lastpage_op_i)
        begin
            tbl_addr_nxt = {pmt_pkg::LAST_PAGE_BASE[11:8], tblp_r};
        end
        else
        begin
            tbl_addr_nxt = {tbhp_r[pmt_pkg::PTR_HI_W-1:0], tblp_r};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tbl_state_r <= pmt_pkg::TBL_IDLE;
            tbl_addr_r <= pmt_pkg::RESET_VECTOR;
            tbl_dest_r <= pmt_pkg::PTR_RESET;
        end
        else
        begin
            case (tbl_state_r)
                pmt_pkg::TBL_IDLE:
                begin
                    if ((table_read_op_i | table_read_lastpage_op_i) & ~prog_active)
                    begin
                        tbl_addr_r <= tbl_addr_nxt;
                        tbl_dest_r <= table_dest_addr_i;
                        tbl_state_r <= pmt_pkg::TBL_READ;
                    end
                end
                pmt_pkg::TBL_READ:
                begin
                    tbl_state_r <= pmt_pkg::TBL_IDLE;
                end
                default:
                begin
                    tbl_state_r <= pmt_pkg::TBL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dm_wr_r <= 1'b0;
            dm_addr_r <= pmt_pkg::PTR_RESET;
            dm_wdata_r <= pmt_pkg::PTR_RESET;
        end
        else
        begin
            dm_wr_r <= (tbl_state_r == pmt_pkg::TBL_READ);
            if (tbl_state_r == pmt_pkg::TBL_READ)
            begin
                dm_addr_r <= tbl_dest_r;
                dm_wdata_r <= prog_mem[tbl_addr_r][7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial programming and debug port
    // ----------------------------------------------------------------
    // Data is sampled on the rising serial clock edge; read data is driven
    // on the falling edge so it is stable for the programmer's next rise.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bit_cnt_r <= 5'h00;
            shift_in_r <= 29'h00000000;
            shift_out_r <= pmt_pkg::WORD_RESET;
            frame_read_r <= 1'b0;
            sda_out_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else if (!prog_active)
        begin
            bit_cnt_r <= 5'h00;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            if (sck_rise)
            begin
                shift_in_r <= {shift_in_r[27:0], sda_sync_r[1]};
                if (bit_cnt_r == 5'h00)
                begin
                    frame_read_r <= (sda_sync_r[1] == pmt_pkg::CMD_READ);
                end
                if (bit_cnt_r == pmt_pkg::FRAME_LEN - 5'h01)
                begin
                    bit_cnt_r <= 5'h00;
                end
                else
                begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
                if ((bit_cnt_r == pmt_pkg::FRAME_ADDR_END - 5'h01) & frame_read_r)
                begin
                    shift_out_r <= prog_mem[{shift_in_r[10:0], sda_sync_r[1]}];
                end
            end
            if (sck_fall)
            begin
                if (frame_read_r & (bit_cnt_r >= pmt_pkg::FRAME_ADDR_END))
                begin
                    sda_oe_r <= 1'b1;
                    sda_out_r <= shift_out_r[15];
                    shift_out_r <= {shift_out_r[14:0], 1'b0};
                end
                else
                begin
                    sda_oe_r <= 1'b0;
                end
            end
        end
    end

    assign mem_wr = prog_active & sck_rise & ~frame_read_r
                    & (bit_cnt_r == pmt_pkg::FRAME_LEN - 5'h01);
    assign mem_wr_addr = shift_in_r[26:15];
    assign mem_wr_data = {shift_in_r[14:0], sda_sync_r[1]};

    always_ff @(posedge clk_i)
    begin
        if (mem_wr)
        begin
            prog_mem[mem_wr_addr] <= mem_wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign shared_func_en_o = ~dbg_sync_r[1];
    assign pc_o = pc_r;
    assign instr_o = instr_r;
    assign instr_valid_o = instr_valid_r;
    assign tblp_o = tblp_r;
    assign tbhp_o = tbhp_r;
    assign table_high_latch_o = table_high_latch_r;
    assign dm_wr_o = dm_wr_r;
    assign dm_addr_o = dm_addr_r;
    assign dm_wdata_o = dm_wdata_r;
    assign prog_serial_data_o = sda_out_r;
    assign prog_serial_data_oe_o = sda_oe_r;

endmodule : pmt_program_memory

//--- testbench/pmt_program_memory_asserts.sv
// Concurrent checks on the program memory and table read ports.
`timescale 1ns/1ps
module pmt_program_memory_asserts (
    // Clock, reset, fetch side and table low pointer write
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pc_load_i,
    input wire logic [11:0] pc_o,
    input wire logic instr_valid_o,
    input wire logic core_stall_o,
    input wire logic [7:0] reg_wdata_i,
    input wire logic tblp_wr_i,
    input wire logic [7:0] tblp_o,
    // Table read and pins
    input wire logic table_read_op_i,
    input wire logic table_read_lastpage_op_i,
    input wire logic [7:0] table_dest_addr_i,
    input wire logic dm_wr_o,
    input wire logic [7:0] dm_addr_o,
    input wire logic [7:0] table_high_latch_o,
    input wire logic prog_mode_i,
    input wire logic on_chip_debug_i,
    input wire logic prog_serial_data_oe_o,
    input wire logic shared_func_en_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_reset_fetch;
        $rose(rst_n_i) && !core_stall_o && !pc_load_i
            |-> pc_o == 12'h000 ##1 (pc_o == 12'h001 && instr_valid_o);
    endproperty
    a_reset_fetch: assert property (p_reset_fetch) else $error("reset fetch wrong");
    property p_fetch_step;
        rst_n_i && !core_stall_o && !pc_load_i |=> pc_o == $past(pc_o) + 12'h001;
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("pc did not step");
    property p_stall_hold;
        core_stall_o |=> pc_o == $past(pc_o) && !instr_valid_o;
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("fetch during stall");
    property p_table_seq;
        (table_read_op_i || table_read_lastpage_op_i) && !core_stall_o
            |=> core_stall_o ##1 (!core_stall_o && dm_wr_o);
    endproperty
    a_table_seq: assert property (p_table_seq) else $error("table read timing");
    property p_dm_addr;
        dm_wr_o |-> dm_addr_o == $past(table_dest_addr_i, 2) ##1 !dm_wr_o;
    endproperty
    a_dm_addr: assert property (p_dm_addr) else $error("low byte target wrong");
    property p_latch_ro;
        !$stable(table_high_latch_o) |-> dm_wr_o;
    endproperty
    a_latch_ro: assert property (p_latch_ro) else $error("latch changed alone");
    property p_ptr_write;
        tblp_wr_i |=> tblp_o == $past(reg_wdata_i);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");
    property p_prog_stall;
        prog_mode_i [*4] |-> core_stall_o;
    endproperty
    a_prog_stall: assert property (p_prog_stall) else $error("core runs in prog");
    property p_debug_shared;
        on_chip_debug_i [*4] |-> !shared_func_en_o;
    endproperty
    a_debug_shared: assert property (p_debug_shared) else $error("shared pin on");
    property p_oe_off;
        !prog_mode_i [*4] |-> !prog_serial_data_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven idle");
    c_table: cover property (table_read_op_i && !core_stall_o);
    c_lastpage: cover property (table_read_lastpage_op_i && !core_stall_o);
    c_drive: cover property (prog_serial_data_oe_o && on_chip_debug_i);
endmodule : pmt_program_memory_asserts

bind pmt_program_memory pmt_program_memory_asserts u_chk (.clk_i, .rst_n_i, .pc_load_i, .pc_o,
    .instr_valid_o, .core_stall_o, .reg_wdata_i, .tblp_wr_i, .tblp_o, .table_read_op_i,
    .table_read_lastpage_op_i, .table_dest_addr_i, .dm_wr_o, .dm_addr_o, .table_high_latch_o,
    .prog_mode_i, .on_chip_debug_i, .prog_serial_data_oe_o, .shared_func_en_o);

//--- testbench/pmt_serial_prog_model.sv
// Behavioural serial programmer that owns the shared clock pin and the data pin.
`timescale 1ns/1ps
module pmt_serial_prog_model (
    // Device side of the data pin
    input wire logic data_i,
    input wire logic data_oe_i,
    // Pin levels seen by the device
    output logic sclk_o,
    output logic sdata_o
);
    logic drv_en = 1'b0;
    logic drv_val = 1'b0;
    logic last = 1'b0;

    initial sclk_o = 1'b0;
    // A floating pin shows the inverse of its last level, so stale bits never pass as read data.
    always @*
    begin
        if (data_oe_i)
            last = data_i;
        else if (drv_en)
            last = drv_val;
    end
    assign sdata_o = data_oe_i ? data_i : (drv_en ? drv_val : ~last);

    // The clock stands low between frames; one bit per 400 ns period.
    task automatic xfer(input logic cmd, input logic [11:0] addr, input logic [15:0] wdata,
        output logic [15:0] rdata);
        logic [28:0] bits;
        bits = {cmd, addr, wdata};
        rdata = 16'h0000;
        drv_en = 1'b1;
        for (int i = 28; i >= 0; i--)
        begin
            if (i == 15 && cmd == pmt_pkg::CMD_READ)
                drv_en = 1'b0;
            drv_val = bits[i];
            #200 sclk_o = 1'b1;
            if (i < 16)
                rdata = {rdata[14:0], sdata_o};
            #200 sclk_o = 1'b0;
        end
        // Release late so a following frame never re-drives the pin in the same step.
        #100 drv_en = 1'b0;
    endtask : xfer
endmodule : pmt_serial_prog_model

//--- testbench/tb_top.sv
// Self-checking bench for the program memory and table read block.
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0, pc_load_i = 1'b0, tblp_wr_i = 1'b0, tbhp_wr_i = 1'b0;
    logic table_high_latch_wr_i = 1'b0, table_read_op_i = 1'b0, table_read_lastpage_op_i = 1'b0;
    logic prog_mode_i = 1'b0, on_chip_debug_i = 1'b0;
    logic [11:0] pc_load_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00, table_dest_addr_i = 8'h00;
    logic prog_serial_clock_i, prog_serial_data_i, prog_serial_data_o, prog_serial_data_oe_o;
    logic instr_valid_o, core_stall_o, dm_wr_o, shared_func_en_o;
    logic [11:0] pc_o;
    logic [15:0] instr_o, rd;
    logic [7:0] tblp_o, tbhp_o, table_high_latch_o, dm_addr_o, dm_wdata_o;
    int error_cnt = 0;
    int compares = 0;

    always #25 clk_i = ~clk_i;

    pmt_program_memory dut (.clk_i, .rst_n_i, .pc_load_i, .pc_load_addr_i, .pc_o, .instr_o,
        .instr_valid_o, .core_stall_o, .reg_wdata_i, .tblp_wr_i, .tbhp_wr_i,
        .table_high_latch_wr_i, .tblp_o, .tbhp_o, .table_high_latch_o, .table_read_op_i,
        .table_read_lastpage_op_i, .table_dest_addr_i, .dm_wr_o, .dm_addr_o, .dm_wdata_o,
        .prog_mode_i, .on_chip_debug_i, .prog_serial_clock_i, .prog_serial_data_i,
        .prog_serial_data_o, .prog_serial_data_oe_o, .shared_func_en_o);
    pmt_serial_prog_model u_prog (.data_i(prog_serial_data_o), .data_oe_i(prog_serial_data_oe_o),
        .sclk_o(prog_serial_clock_i), .sdata_o(prog_serial_data_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic set_prog(input logic dbg, input logic on);
        @(posedge clk_i);
        prog_mode_i <= on;
        on_chip_debug_i <= dbg;
        repeat (4) @(posedge clk_i);
        #1 check(16'(core_stall_o), 16'(on));
    endtask : set_prog

    // Words go in over the serial pin; one is read back the same way.
    task automatic t_prog;
        set_prog(1'b0, 1'b1);
        u_prog.xfer(~pmt_pkg::CMD_READ, 12'h000, 16'h3C5A, rd);
        u_prog.xfer(~pmt_pkg::CMD_READ, 12'hF05, 16'h120F, rd);
        u_prog.xfer(~pmt_pkg::CMD_READ, 12'hF06, 16'h001A, rd);
        u_prog.xfer(pmt_pkg::CMD_READ, 12'hF05, 16'h0000, rd);
        check(rd, 16'h120F);
        set_prog(1'b0, 1'b0);
    endtask : t_prog

    task automatic t_reset;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        #1 check(16'(pc_o), 16'h0000);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1 check(instr_o, 16'h3C5A);
        check(16'(pc_o), 16'h0001);
        @(posedge clk_i);
        pc_load_i <= 1'b1;
        pc_load_addr_i <= 12'hF05;
        @(posedge clk_i);
        pc_load_i <= 1'b0;
        #1 check(16'(pc_o), 16'h0F05);
        @(posedge clk_i);
        #1 check(instr_o, 16'h120F);
    endtask : t_reset

    task automatic t_table(input logic lp, input logic [7:0] hi, input logic [7:0] lo,
        input logic [7:0] dst, input logic [15:0] w);
        @(posedge clk_i);
        reg_wdata_i <= hi;
        tbhp_wr_i <= 1'b1;
        @(posedge clk_i);
        tbhp_wr_i <= 1'b0;
        reg_wdata_i <= lo;
        tblp_wr_i <= 1'b1;
        @(posedge clk_i);
        tblp_wr_i <= 1'b0;
        table_read_op_i <= !lp;
        table_read_lastpage_op_i <= lp;
        table_dest_addr_i <= dst;
        @(posedge clk_i);
        table_read_op_i <= 1'b0;
        table_read_lastpage_op_i <= 1'b0;
        #1 check(16'(core_stall_o), 16'h0001);
        @(posedge clk_i);
        #1 check(16'(dm_wr_o), 16'h0001);
        check(16'(dm_addr_o), 16'(dst));
        check(16'(dm_wdata_o), 16'(w[7:0]));
        check(16'(table_high_latch_o), 16'(w[15:8]));
        @(posedge clk_i);
        reg_wdata_i <= ~w[15:8];
        table_high_latch_wr_i <= 1'b1;
        @(posedge clk_i);
        table_high_latch_wr_i <= 1'b0;
        #1 check(16'(table_high_latch_o), 16'(w[15:8]));
        check({tbhp_o, tblp_o}, {hi, lo});
    endtask : t_table

    // Debug owns the shared pins, and programming still works through them.
    task automatic t_debug;
        set_prog(1'b1, 1'b1);
        check(16'(shared_func_en_o), 16'h0000);
        u_prog.xfer(~pmt_pkg::CMD_READ, 12'hFFF, 16'hA55A, rd);
        u_prog.xfer(pmt_pkg::CMD_READ, 12'hFFF, 16'h0000, rd);
        check(rd, 16'hA55A);
        set_prog(1'b0, 1'b0);
        check(16'(shared_func_en_o), 16'h0001);
    endtask : t_debug

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_prog();
        t_reset();
        t_table(1'b0, 8'hAF, 8'h06, 8'h80, 16'h001A);
        t_table(1'b1, 8'h02, 8'h05, 8'h81, 16'h120F);
        t_table(1'b0, 8'h00, 8'h00, 8'h82, 16'h3C5A);
        t_debug();
        t_table(1'b1, 8'h00, 8'hFF, 8'hC3, 16'hA55A);
        end_sim();
    end
endmodule : tb_top
